//--- logic/rx_sig_pkg.sv
/*
  Shared constants and carrier types for the receive signaling
  extraction and substitution block.
  Assumes APB with 32-bit data and a 16-bit byte address.
*/
`default_nettype none
package rx_sig_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TS = 24;
  localparam int unsigned TS_W = 5;
  localparam int unsigned ADDR_W = 16;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] RX_SIG_CTL_IDX = 16'h03a0;
  localparam logic [ADDR_W-1:0] RX_SIG_SUB_IDX = 16'h03c0;
  localparam logic [ADDR_W-1:0] RX_SIG_ARR_IDX = 16'h0500;
  localparam logic [ADDR_W-1:0] RX_SIG_CFG_IDX = 16'h03f0;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned SUB_EN_BIT = 6;
  localparam int unsigned OH_EN_BIT = 5;
  localparam int unsigned DEB_EN_BIT = 4;
  localparam int unsigned SUB_FMT_LSB = 2;
  localparam int unsigned EXT_FMT_LSB = 0;
  localparam logic [6:0] CTL_RESET = 7'h00;
  localparam logic [3:0] SUB_RESET = 4'h0;
  localparam logic [3:0] ARR_RESET = 4'h0;
  // config register: bit 0 enables the receive signaling interface
  localparam int unsigned SIG_IF_EN_BIT = 0;
  localparam logic CFG_RESET = 1'b0;

  // ----------------------------------------------------------------
  // format encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SUB_ALL_ONES = 2'h0,
    SUB_16_CODE = 2'h1,
    SUB_4_CODE = 2'h2,
    SUB_2_CODE = 2'h3
  } sub_fmt_t;

  typedef enum logic [1:0] {
    EXT_NONE = 2'h0,
    EXT_ABCD = 2'h1,
    EXT_AB = 2'h2,
    EXT_A = 2'h3
  } ext_fmt_t;

  // ----------------------------------------------------------------
  // carriers: abcd is {A,B,C,D} with A in bit 3
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [TS_W-1:0] ts;
    logic [3:0] abcd;
  } sig_word_t;

  typedef struct packed {
    logic valid;
    logic [TS_W-1:0] ts;
    logic [3:0] abcd;
    logic [3:0] mask;
  } sig_ext_t;

endpackage

`default_nettype wire

//--- logic/rx_sig_subst_extract.sv
/*
  Receive signaling extraction and substitution for 24 timeslots,
  with an APB slave for the per-timeslot registers.
  Word indices: control 0x3a0+n, substitution 0x3c0+n, array
  0x500+n (read only), interface enable 0x3f0; the byte address is
  four times the index. Every access takes exactly one wait state.
  Control bit 4 is stored only; reserved bits read as zero.
  Timeslot numbers 24 to 31 pass through with no extraction.
  Assumes the framer presents one signaling word per timeslot on
  pclk, already aligned to the receive stream, and that software
  loads substitution values before it selects a coded format.
*/
// Our own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module rx_sig_subst_extract
  import rx_sig_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sig_word_t rx_sig_in,
  output sig_word_t rx_serial_pcm_output,
  output sig_ext_t rx_signaling_output_pin,
  output sig_ext_t rx_overhead_output
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ctl;
    logic sub;
    logic arr;
    logic cfg;
    logic [TS_W-1:0] ts;
  } dec_t;

  // maps a byte address onto a register group and timeslot
  function automatic dec_t decode(input logic [ADDR_W-1:0] addr);
    dec_t d;
    logic [ADDR_W-1:0] idx;
    d = '0;
    idx = {2'h0, addr[ADDR_W-1:2]};
    if (addr[1:0] == 2'h0) begin
      if (idx >= RX_SIG_CTL_IDX && idx < RX_SIG_CTL_IDX + 16'(NUM_TS)) begin
        d.ctl = 1'b1;
        d.ts = TS_W'(idx - RX_SIG_CTL_IDX);
      end else if (idx >= RX_SIG_SUB_IDX && idx < RX_SIG_SUB_IDX + 16'(NUM_TS)) begin
        d.sub = 1'b1;
        d.ts = TS_W'(idx - RX_SIG_SUB_IDX);
      end else if (idx >= RX_SIG_ARR_IDX && idx < RX_SIG_ARR_IDX + 16'(NUM_TS)) begin
        d.arr = 1'b1;
        d.ts = TS_W'(idx - RX_SIG_ARR_IDX);
      end else if (idx == RX_SIG_CFG_IDX) begin
        d.cfg = 1'b1;
      end
    end
    return d;
  endfunction

  // extraction mask for a format, A in bit 3
  function automatic logic [3:0] ext_mask(input logic [1:0] fmt);
    logic [3:0] m;
    case (ext_fmt_t'(fmt))
      EXT_NONE: m = 4'h0;
      EXT_ABCD: m = 4'hf;
      EXT_AB: m = 4'hc;
      EXT_A: m = 4'h8;
      default: m = 4'h0;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  dec_t dec;
  logic access;
  logic bad_access;
  logic rd_en;
  logic wr_en;

  assign dec = decode(paddr);
  // one wait state: pready rises in the second access cycle
  assign access = psel && penable && !pready_ff;
  // unmapped, misaligned, or a write aimed at the read-only array
  assign bad_access = !(dec.ctl || dec.sub || dec.arr || dec.cfg) || (pwrite && dec.arr);
  // reads capture data in the first access cycle
  assign rd_en = access && !pwrite;
  // writes land only at the completing edge
  assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;

  // ready pulse and error flag per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access && bad_access;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [6:0] ctl_ff [NUM_TS];
  logic [3:0] sub_ff [NUM_TS];
  logic [3:0] arr_ff [NUM_TS];
  logic sig_if_en_ff;

  genvar g;
  generate
    for (g = 0; g < NUM_TS; g++) begin : g_ts
      // per-timeslot strobes and next array value
      logic ctl_we;
      logic sub_we;
      logic arr_upd;
      logic [3:0] ext_sel;
      logic [3:0] nxt_arr;

      // writes and received words aimed at this timeslot
      assign ctl_we = wr_en && dec.ctl && (dec.ts == TS_W'(g));
      assign sub_we = wr_en && dec.sub && (dec.ts == TS_W'(g));
      assign arr_upd = rx_sig_in.valid && (rx_sig_in.ts == TS_W'(g));
      // extracted positions take raw bits, the rest hold
      assign ext_sel = ext_mask(ctl_ff[g][EXT_FMT_LSB +: 2]);
      assign nxt_arr = (arr_ff[g] & ~ext_sel) | (rx_sig_in.abcd & ext_sel);

      // control register of one timeslot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctl_ff[g] <= CTL_RESET;
        end else if (ctl_we) begin
          ctl_ff[g] <= pwdata[6:0];
        end
      end

      // substitution register of one timeslot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sub_ff[g] <= SUB_RESET;
        end else if (sub_we) begin
          sub_ff[g] <= pwdata[3:0];
        end
      end

      // array keeps received bits of extracted positions
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          arr_ff[g] <= ARR_RESET;
        end else if (arr_upd) begin
          arr_ff[g] <= nxt_arr;
        end
      end
    end
  endgenerate

  // interface enable for the signaling pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_if_en_ff <= CFG_RESET;
    end else if (wr_en && dec.cfg) begin
      sig_if_en_ff <= pwdata[SIG_IF_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [31:0] nxt_prdata;

  // read mux, unmapped reads and unused upper bits give zero
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (dec.ctl) begin
      nxt_prdata = {25'h0, ctl_ff[dec.ts]};
    end else if (dec.sub) begin
      nxt_prdata = {28'h0, sub_ff[dec.ts]};
    end else if (dec.arr) begin
      nxt_prdata = {28'h0, arr_ff[dec.ts]};
    end else if (dec.cfg) begin
      nxt_prdata = {31'h0, sig_if_en_ff};
    end
  end

  // read data, captured as pready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------
  // stream path
  // ----------------------------------------------------------------
  // view of the timeslot now on the input
  logic ts_ok;
  logic [6:0] cur_ctl;
  logic [3:0] cur_sub;
  logic [3:0] cur_mask;
  logic [3:0] ext_abcd;
  logic ext_any;
  logic [3:0] nxt_pcm_abcd;

  // timeslots past the last one pass untouched
  assign ts_ok = rx_sig_in.ts < TS_W'(NUM_TS);
  // settings of the timeslot now on the input
  assign cur_ctl = ts_ok ? ctl_ff[rx_sig_in.ts] : CTL_RESET;
  assign cur_sub = ts_ok ? sub_ff[rx_sig_in.ts] : SUB_RESET;
  assign cur_mask = ext_mask(cur_ctl[EXT_FMT_LSB +: 2]);
  // raw received bits of the extracted positions only
  assign ext_abcd = rx_sig_in.abcd & cur_mask;
  assign ext_any = rx_sig_in.valid && (cur_mask != 4'h0);

  // substituted signaling for the pcm stream
  always_comb begin
    nxt_pcm_abcd = rx_sig_in.abcd;
    if (cur_ctl[SUB_EN_BIT]) begin
      case (sub_fmt_t'(cur_ctl[SUB_FMT_LSB +: 2]))
        SUB_ALL_ONES: nxt_pcm_abcd = 4'hf;
        SUB_16_CODE: nxt_pcm_abcd = cur_sub;
        SUB_4_CODE: nxt_pcm_abcd = {cur_sub[3:2], rx_sig_in.abcd[1:0]};
        SUB_2_CODE: nxt_pcm_abcd = {cur_sub[3], rx_sig_in.abcd[2:0]};
        default: nxt_pcm_abcd = rx_sig_in.abcd;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output words
  // ----------------------------------------------------------------
  sig_word_t nxt_pcm;
  sig_ext_t nxt_pin;
  sig_ext_t nxt_oh;
  sig_word_t pcm_ff;
  sig_ext_t sig_pin_ff;
  sig_ext_t oh_ff;

  // next output words, field by field
  always_comb begin
    nxt_pcm.valid = rx_sig_in.valid;
    nxt_pcm.ts = rx_sig_in.ts;
    nxt_pcm.abcd = nxt_pcm_abcd;
    nxt_pin.valid = ext_any && sig_if_en_ff;
    nxt_pin.ts = rx_sig_in.ts;
    nxt_pin.abcd = ext_abcd;
    nxt_pin.mask = cur_mask;
    nxt_oh.valid = ext_any && cur_ctl[OH_EN_BIT];
    nxt_oh.ts = rx_sig_in.ts;
    nxt_oh.abcd = ext_abcd;
    nxt_oh.mask = cur_mask;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcm_ff <= '0;
    end else begin
      pcm_ff <= nxt_pcm;
    end
  end

  // signaling pin carries raw extracted bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_pin_ff <= '0;
    end else begin
      sig_pin_ff <= nxt_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oh_ff <= '0;
    end else begin
      oh_ff <= nxt_oh;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign rx_serial_pcm_output = pcm_ff;
  assign rx_signaling_output_pin = sig_pin_ff;
  assign rx_overhead_output = oh_ff;

endmodule // rx_sig_subst_extract

`default_nettype wire

//--- tb/rx_sig_props.sv
/*
  Checker for the apb handshake and the signaling stream outputs.
  Assumes it is bound to rx_sig_subst_extract and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module rx_sig_props
  import rx_sig_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire sig_word_t rx_sig_in,
  input wire sig_word_t rx_serial_pcm_output,
  input wire sig_ext_t rx_signaling_output_pin,
  input wire sig_ext_t rx_overhead_output
);
  // short aliases for the stream ports
  wire sig_word_t si = rx_sig_in;
  wire sig_word_t po = rx_serial_pcm_output;
  wire sig_ext_t pn = rx_signaling_output_pin;
  wire sig_ext_t oh = rx_overhead_output;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------
  // apb handshake
  // ----------------
  sequence s_setup; psel && !penable; endsequence
  sequence s_wait; psel && penable && !pready; endsequence
  property p_one_wait; s_setup ##1 s_wait |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("apb answer late");
  property p_no_early; s_setup |=> !pready; endproperty
  a_no_early: assert property (p_no_early) else $error("apb answer early");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  // ----------------
  // stream
  // ----------------
  property p_pcm_lat; si.valid |=> po.valid && po.ts == $past(si.ts); endproperty
  a_pcm_lat: assert property (p_pcm_lat) else $error("pcm word missing");
  property p_pcm_idle; !si.valid |=> !po.valid && !pn.valid && !oh.valid; endproperty
  a_pcm_idle: assert property (p_pcm_idle) else $error("output without input");
  property p_out_range;
    si.valid && si.ts >= NUM_TS |=> po.abcd == $past(si.abcd) && !pn.valid && !oh.valid;
  endproperty
  a_out_range: assert property (p_out_range) else $error("bad timeslot touched");
  property p_pin_raw;
    si.valid |=> !pn.valid || (pn.abcd == ($past(si.abcd) & pn.mask) && pn.ts == $past(si.ts));
  endproperty
  a_pin_raw: assert property (p_pin_raw) else $error("pin not raw value");
  property p_mask; pn.valid |-> pn.mask inside {4'hf, 4'hc, 4'h8}; endproperty
  a_mask: assert property (p_mask) else $error("bad extraction mask");
  property p_oh_same; oh.valid && pn.valid |-> oh == pn; endproperty
  a_oh_same: assert property (p_oh_same) else $error("overhead differs");
endmodule // rx_sig_props

bind rx_sig_subst_extract rx_sig_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .rx_sig_in(rx_sig_in),
  .rx_serial_pcm_output(rx_serial_pcm_output),
  .rx_signaling_output_pin(rx_signaling_output_pin),
  .rx_overhead_output(rx_overhead_output)
);
`default_nettype wire

//--- tb/rx_sig_backplane.sv
/*
  Backplane sink model: takes every pcm word and counts it.
  Assumes the same clock and reset as the block.
*/
`timescale 1ns/1ns
`default_nettype none
module rx_sig_backplane
  import rx_sig_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire sig_word_t pcm,
  output logic [15:0] words_ff
);
  // count words landing on the backplane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      words_ff <= 16'h0000;
    end else if (pcm.valid) begin
      words_ff <= words_ff + 16'h0001;
    end
  end
endmodule // rx_sig_backplane
`default_nettype wire

//--- tb/rx_sig_subst_extract_bench.sv
/*
  Self-checking bench: apb register traffic and random signaling words.
  Assumes the checker is bound beside the block.
*/
`timescale 1ns/1ns
`default_nettype none
module rx_sig_subst_extract_bench
  import rx_sig_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000, words;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, cfg;
  sig_word_t rx_sig_in = '0, pcm;
  sig_ext_t pin, oh;
  logic [6:0] ctl [NUM_TS];
  logic [3:0] sub [NUM_TS], arr [NUM_TS];
  logic [32:0] q_rd [$], q_pcm [$], q_pin [$], q_oh [$];
  int err_count = 0, checks_done = 0, sent = 0;
  always #5 pclk = ~pclk;
  rx_sig_subst_extract uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_sig_in(rx_sig_in), .rx_serial_pcm_output(pcm),
    .rx_signaling_output_pin(pin), .rx_overhead_output(oh));
  rx_sig_backplane u_sink (.pclk(pclk), .presetn(presetn), .pcm(pcm), .words_ff(words));
  // ----------------
  // checking
  // ----------------
  task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // outputs stand one cycle; look mid-cycle
  always @(negedge pclk) begin : mon
    logic [32:0] e;
    if (pready === 1'b1) begin
      e = q_rd.pop_front();
      chk("pslverr", 33'(e[32]), 33'(pslverr));
      if (!pwrite) chk("prdata", 33'(e[31:0]), 33'(prdata));
    end
    if (pcm.valid === 1'b1) chk("pcm", q_pcm.pop_front(), 33'(pcm));
    if (pin.valid === 1'b1) chk("pin", q_pin.pop_front(), 33'(pin));
    if (oh.valid === 1'b1) chk("oh", q_oh.pop_front(), 33'(oh));
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    wrap_up();
  end
  // ----------------
  // drivers
  // ----------------
  function automatic logic [15:0] ad(input logic [15:0] b, input int t);
    return b + 16'(t * 4);
  endfunction
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    q_rd.push_back(e);
    @(posedge pclk) penable <= 1'b1;
    // release only after the edge that samples pready high
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task send(input logic [4:0] ts, input logic [3:0] v);
    logic [3:0] m, o;
    m = 4'h0;
    o = v;
    if (ts < NUM_TS) begin
      case (ctl[ts][1:0])
        2'h1: m = 4'hf;
        2'h2: m = 4'hc;
        2'h3: m = 4'h8;
        default: m = 4'h0;
      endcase
      if (ctl[ts][SUB_EN_BIT]) begin
        case (ctl[ts][3:2])
          2'h0: o = 4'hf;
          2'h1: o = sub[ts];
          2'h2: o = {sub[ts][3:2], v[1:0]};
          default: o = {sub[ts][3], v[2:0]};
        endcase
      end
      arr[ts] = (arr[ts] & ~m) | (v & m);
    end
    q_pcm.push_back(33'({1'b1, ts, o}));
    if (m != 4'h0 && cfg) q_pin.push_back(33'({1'b1, ts, v & m, m}));
    if (m != 4'h0 && ctl[ts][OH_EN_BIT]) q_oh.push_back(33'({1'b1, ts, v & m, m}));
    rx_sig_in <= {1'b1, ts, v};
    sent++;
    @(posedge pclk);
  endtask
  task burst(input int n);
    repeat (n) send(5'($urandom_range(25)), 4'($urandom));
    rx_sig_in <= '0;
    repeat (3) @(posedge pclk);
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    logic [6:0] c;
    logic [3:0] s;
    cfg = 1'b0;
    foreach (ctl[i]) begin
      ctl[i] = 7'h00;
      sub[i] = 4'h0;
      arr[i] = 4'h0;
    end
    void'($urandom(32722));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < NUM_TS; i += 23) begin
      apb(1'b0, ad(16'h0e80, i), 32'h0, 33'h0);
      apb(1'b0, ad(16'h0f00, i), 32'h0, 33'h0);
    end
    apb(1'b0, 16'h0004, 32'h0, {1'b1, 32'h0});
    apb(1'b0, 16'h0e81, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 16'h1400, 32'hf, {1'b1, 32'h0});
    apb(1'b1, 16'h0f00, 32'hffffffff, 33'h0);
    apb(1'b0, 16'h0f00, 32'h0, 33'hf);
    apb(1'b1, 16'h0e80, 32'hffffffff, 33'h0);
    apb(1'b0, 16'h0e80, 32'h0, 33'h7f);
    apb(1'b1, 16'h0fc0, 32'h1, 33'h0);
    cfg = 1'b1;
    // substitution values go in before the format
    for (int i = 0; i < NUM_TS; i++) begin
      s = 4'($urandom);
      c = {~i[4], 2'($urandom), i[1:0], i[3:2]};
      apb(1'b1, ad(16'h0f00, i), {28'h0, s}, 33'h0);
      apb(1'b1, ad(16'h0e80, i), {25'h0, c}, 33'h0);
      sub[i] = s;
      ctl[i] = c;
    end
    burst(300);
    for (int i = 0; i < NUM_TS; i++) apb(1'b0, ad(16'h1400, i), 32'h0, 33'(arr[i]));
    apb(1'b1, 16'h0fc0, 32'h0, 33'h0);
    cfg = 1'b0;
    burst(100);
    chk("words", 33'(sent), 33'(words));
    chk("left", 33'h0, 33'(q_rd.size() + q_pcm.size() + q_pin.size() + q_oh.size()));
    wrap_up();
  end
endmodule // rx_sig_subst_extract_bench
`default_nettype wire
